// ==== usart_params.svh ====
// offsets, field positions, reset values and counts of the serial port
//----------------------------------------------------------------------
`ifndef USART_PARAMS_SVH
`define USART_PARAMS_SVH
// register indices; byte address is four times the index
`define IDX_RX_CTL 8'h18
`define IDX_TX_CTL 8'h98
`define IDX_DIV 8'h99
`define IDX_TX_BUF 8'h19
`define IDX_RX_BUF 8'h1a
`define IDX_FLAGS 8'h0c
`define IDX_INT_EN 8'h8c
// field positions
`define B_TRANSMIT_INTERRUPT_ENABLE 4
`define B_RECEIVE_INTERRUPT_ENABLE 5
`define B_TRANSMIT_BUFFER_FREE_FLAG 4
`define B_RECEIVE_COMPLETE_FLAG 5
// reset values
`define RST_TX_CTL 8'h02
`define RST_RX_CTL 8'h00
`define RST_DIV 8'h00
// bit periods less one, in oscillator clocks per (divisor+1)
`define PRE_ASYNC_LO 6'd63
`define PRE_ASYNC_HI 6'd15
`define PRE_SYNC 6'd3
`define BITS_8 4'd8
`define BITS_9 4'd9
`endif

// ==== usart_pkg.sv ====
// types shared by the serial port
package usart_pkg;
    typedef struct packed {
        logic clock_source_select;
        logic tx9;
        logic transmit_enable;
        logic sync;
        logic high_speed_baud_select;
        logic tx_ninth_bit_value;
    } tx_ctl_s;
    typedef struct packed {
        logic serial_port_enable;
        logic rx9;
        logic single_receive_enable;
        logic continuous_receive_enable;
    } rx_ctl_s;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_e;
endpackage

// ==== usart_sync_slave_baud_gen.sv ====
// serial port: baud generator, clocked master/slave shifting, apb registers
`timescale 1ns/1ps
`default_nettype none
`include "usart_params.svh"
module usart_sync_slave_baud_gen import usart_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ck_in,
    output logic ck_out,
    output logic ck_oe,
    input wire logic dt_in,
    output logic dt_out,
    output logic dt_oe,
    output logic baud_tick,
    output logic wake_irq
);
    //------------------------------------------------------------------
    // registers and bus decode
    //------------------------------------------------------------------
    tx_ctl_s txc;
    rx_ctl_s rxc;
    logic [7:0] baud_divisor;
    logic [7:0] tx_hold;
    logic [7:0] rx_hold;
    logic rx_ninth_bit_value;
    logic overrun_error_flag;
    logic transmit_buffer_free_flag;
    logic receive_complete_flag;
    logic transmit_interrupt_enable;
    logic receive_interrupt_enable;
    logic shift_register_empty;
    logic [7:0] idx;
    logic mapped;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] rd_val;
    // named copies so the reset fields can be sliced
    localparam logic [7:0] TX_RST = `RST_TX_CTL;
    localparam logic [7:0] RX_RST = `RST_RX_CTL;

    assign idx = paddr[9:2];
    assign mapped = paddr[31:10] == 22'h0 && paddr[1:0] == 2'b00 &&
        (idx == `IDX_RX_CTL || idx == `IDX_TX_CTL || idx == `IDX_DIV ||
         idx == `IDX_TX_BUF || idx == `IDX_RX_BUF ||
         idx == `IDX_FLAGS || idx == `IDX_INT_EN);
    assign wr_acc = psel && penable && pwrite && mapped;
    assign rd_acc = psel && penable && !pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        rd_val = 8'h00;
        case (idx)
            // bit 3 of both control registers reads zero
            `IDX_TX_CTL: rd_val = {txc.clock_source_select, txc.tx9, txc.transmit_enable, txc.sync,
                1'b0, txc.high_speed_baud_select, shift_register_empty, txc.tx_ninth_bit_value};
            `IDX_RX_CTL: rd_val = {rxc.serial_port_enable, rxc.rx9, rxc.single_receive_enable, rxc.continuous_receive_enable,
                1'b0, 1'b0, overrun_error_flag, rx_ninth_bit_value};
            `IDX_DIV: rd_val = baud_divisor;
            `IDX_RX_BUF: rd_val = rx_hold;
            `IDX_FLAGS: rd_val = {2'b00, receive_complete_flag, transmit_buffer_free_flag, 4'h0};
            `IDX_INT_EN: rd_val = {2'b00, receive_interrupt_enable, transmit_interrupt_enable, 4'h0};
            default: rd_val = 8'h00;
        endcase
    end

    // read data is captured in the setup cycle so the access needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= {24'h0, rd_val};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txc <= tx_ctl_s'({TX_RST[7:4], TX_RST[2], TX_RST[0]});
            rxc <= rx_ctl_s'(RX_RST[7:4]);
            baud_divisor <= `RST_DIV;
            transmit_interrupt_enable <= 1'b0;
            receive_interrupt_enable <= 1'b0;
        end else if (wr_acc) begin
            case (idx)
                `IDX_TX_CTL: txc <= tx_ctl_s'({pwdata[7:4], pwdata[2],
                    pwdata[0]});
                `IDX_RX_CTL: rxc <= rx_ctl_s'(pwdata[7:4]);
                `IDX_DIV: baud_divisor <= pwdata[7:0];
                `IDX_INT_EN: begin
                    transmit_interrupt_enable <= pwdata[`B_TRANSMIT_INTERRUPT_ENABLE];
                    receive_interrupt_enable <= pwdata[`B_RECEIVE_INTERRUPT_ENABLE];
                end
                default: ;
            endcase
        end
    end

    //------------------------------------------------------------------
    // baud rate generator
    //------------------------------------------------------------------
    logic [7:0] div_cnt;
    logic [5:0] pre_cnt;
    logic [5:0] pre_max;
    logic div_wr;
    logic master;
    logic m_rise;
    logic m_fall;

    assign div_wr = wr_acc && idx == `IDX_DIV;
    assign master = rxc.serial_port_enable && txc.sync && txc.clock_source_select;
    always_comb begin
        if (txc.sync) begin
            pre_max = `PRE_SYNC;
        end else if (txc.high_speed_baud_select) begin
            pre_max = `PRE_ASYNC_HI;
        end else begin
            pre_max = `PRE_ASYNC_LO;
        end
    end

    // divisor runs innermost so the clocked-mode clock is a clean square
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 8'h00;
            pre_cnt <= 6'h00;
        end else if (div_wr || !rxc.serial_port_enable) begin
            div_cnt <= 8'h00;
            pre_cnt <= 6'h00;
        end else if (div_cnt == baud_divisor) begin
            div_cnt <= 8'h00;
            pre_cnt <= (pre_cnt == pre_max) ? 6'h00 : pre_cnt + 6'h01;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    assign baud_tick = rxc.serial_port_enable && !div_wr &&
        div_cnt == baud_divisor && pre_cnt == pre_max;
    assign m_fall = master && baud_tick;
    assign m_rise = master && !div_wr && div_cnt == baud_divisor &&
        pre_cnt == (pre_max >> 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_out <= 1'b0;
        end else if (!master || m_fall) begin
            ck_out <= 1'b0;
        end else if (m_rise) begin
            ck_out <= 1'b1;
        end
    end
    assign ck_oe = master;

    //------------------------------------------------------------------
    // pin synchronisers: a change counts once stages two and three agree
    //------------------------------------------------------------------
    logic [2:0] ck_sy;
    logic [2:0] dt_sy;
    logic ck_lvl;
    logic dt_lvl;
    logic s_rise;
    logic s_fall;
    logic sh_rise;
    logic sh_fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_sy <= 3'b000;
            dt_sy <= 3'b000;
        end else begin
            ck_sy <= {ck_sy[1:0], ck_in};
            dt_sy <= {dt_sy[1:0], dt_in};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_lvl <= 1'b0;
            dt_lvl <= 1'b0;
        end else begin
            if (ck_sy[1] == ck_sy[2]) begin
                ck_lvl <= ck_sy[2];
            end
            if (dt_sy[1] == dt_sy[2]) begin
                dt_lvl <= dt_sy[2];
            end
        end
    end

    // slave edges depend on no core activity, so shifting goes on in halt
    assign s_rise = ck_sy[1] && ck_sy[2] && !ck_lvl;
    assign s_fall = !ck_sy[1] && !ck_sy[2] && ck_lvl;
    assign sh_rise = master ? m_rise :
        (rxc.serial_port_enable && txc.sync && !txc.clock_source_select && s_rise);
    assign sh_fall = master ? m_fall :
        (rxc.serial_port_enable && txc.sync && !txc.clock_source_select && s_fall);

    //------------------------------------------------------------------
    // transmit path
    //------------------------------------------------------------------
    tx_state_e tx_st;
    logic [8:0] transmit_shift_register;
    logic [3:0] tx_cnt;
    logic tx_load;
    logic tx_done;
    logic buf_wr;

    assign buf_wr = wr_acc && idx == `IDX_TX_BUF;
    assign tx_load = tx_st == TX_IDLE && !transmit_buffer_free_flag && txc.transmit_enable && rxc.serial_port_enable &&
        txc.sync;
    assign tx_done = tx_st == TX_SHIFT && sh_fall && tx_cnt == 4'd1;
    assign shift_register_empty = tx_st == TX_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_hold <= 8'h00;
        end else if (buf_wr) begin
            tx_hold <= pwdata[7:0];
        end
    end

    // the free flag is cleared by a buffer write, set when the shifter
    // takes the word; a write in the same cycle as a load leaves the flag set and its word unsent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_buffer_free_flag <= 1'b1;
        end else if (tx_load) begin
            transmit_buffer_free_flag <= 1'b1;
        end else if (buf_wr) begin
            transmit_buffer_free_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st <= TX_IDLE;
            transmit_shift_register <= 9'h000;
            tx_cnt <= 4'h0;
            dt_out <= 1'b0;
        end else begin
            case (tx_st)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_st <= TX_SHIFT;
                        transmit_shift_register <= {txc.tx_ninth_bit_value, tx_hold};
                        tx_cnt <= txc.tx9 ? `BITS_9 : `BITS_8;
                        dt_out <= tx_hold[0];
                    end
                end
                TX_SHIFT: begin
                    if (!txc.transmit_enable || !rxc.serial_port_enable) begin
                        tx_st <= TX_IDLE;
                    end else if (tx_done) begin
                        tx_st <= TX_IDLE;
                    end else if (sh_fall) begin
                        transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
                        dt_out <= transmit_shift_register[1];
                        tx_cnt <= tx_cnt - 4'd1;
                    end
                end
                default: tx_st <= TX_IDLE;
            endcase
        end
    end

    //------------------------------------------------------------------
    // receive path
    //------------------------------------------------------------------
    logic rx_en;
    logic [8:0] receive_shift_register;
    logic [3:0] rx_cnt;
    logic [3:0] rx_len;
    logic rx_done;
    logic rx_rd;

    // single receive only matters in master mode
    assign rx_en = rxc.serial_port_enable && txc.sync &&
        (rxc.continuous_receive_enable || (txc.clock_source_select && rxc.single_receive_enable));
    assign rx_len = rxc.rx9 ? `BITS_9 : `BITS_8;
    assign rx_done = rx_en && sh_rise && rx_cnt == rx_len - 4'd1;
    assign rx_rd = rd_acc && idx == `IDX_RX_BUF;
    assign dt_oe = rxc.serial_port_enable && txc.sync && txc.transmit_enable && !rx_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_shift_register <= 9'h000;
            rx_cnt <= 4'h0;
        end else if (!rx_en) begin
            rx_cnt <= 4'h0;
        end else if (sh_rise) begin
            receive_shift_register <= {dt_lvl, receive_shift_register[8:1]};
            rx_cnt <= rx_done ? 4'h0 : rx_cnt + 4'd1;
        end
    end

    // an eight-bit word arrives in the top of the shifter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hold <= 8'h00;
            rx_ninth_bit_value <= 1'b0;
        end else if (rx_done && !receive_complete_flag) begin
            rx_hold <= rxc.rx9 ? receive_shift_register[8:1] : {dt_lvl, receive_shift_register[8:2]};
            rx_ninth_bit_value <= rxc.rx9 ? dt_lvl : 1'b0;
        end
    end

    // completion wins over a read of the buffer in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_complete_flag <= 1'b0;
        end else if (rx_done) begin
            receive_complete_flag <= 1'b1;
        end else if (rx_rd) begin
            receive_complete_flag <= 1'b0;
        end
    end

    // a word finished while the last one is unread is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_error_flag <= 1'b0;
        end else if (!rxc.continuous_receive_enable) begin
            overrun_error_flag <= 1'b0;
        end else if (rx_done && receive_complete_flag) begin
            overrun_error_flag <= 1'b1;
        end
    end

    // wake line also serves as the core interrupt request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_irq <= 1'b0;
        end else begin
            wake_irq <= (transmit_buffer_free_flag && transmit_interrupt_enable) || (receive_complete_flag && receive_interrupt_enable);
        end
    end

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    sequence s_div_write;
        div_wr;
    endsequence
    a_div_restart: assert property (@(posedge pclk) disable iff (!presetn)
        s_div_write |=> div_cnt == 8'h00 && pre_cnt == 6'h00)
        else $error("divisor write did not restart the timer");
    // a register write may change mode or restart the timer mid-period
    a_sync_period: assert property (@(posedge pclk)
        disable iff (!presetn || wr_acc)
        baud_tick && txc.sync && baud_divisor == 8'h00 && !div_wr
        |=> !baud_tick [*3] ##1 baud_tick)
        else $error("clocked bit period is not four clocks");
    a_hi_period: assert property (@(posedge pclk)
        disable iff (!presetn || wr_acc)
        baud_tick && !txc.sync && txc.high_speed_baud_select && baud_divisor == 8'h00 &&
        !div_wr |=> ##15 baud_tick)
        else $error("high speed bit period is not sixteen clocks");
    a_load_free: assert property (@(posedge pclk) disable iff (!presetn)
        tx_load |=> transmit_buffer_free_flag && tx_st == TX_SHIFT)
        else $error("load did not set the free flag");
    a_hold_wait: assert property (@(posedge pclk) disable iff (!presetn)
        tx_st == TX_SHIFT && !transmit_buffer_free_flag && !tx_done && txc.transmit_enable && rxc.serial_port_enable
        |=> !transmit_buffer_free_flag)
        else $error("free flag set while a word still waits");
    a_write_start: assert property (@(posedge pclk) disable iff (!presetn)
        buf_wr && tx_st == TX_IDLE && txc.transmit_enable && rxc.serial_port_enable && txc.sync
        |=> ##1 tx_st == TX_SHIFT)
        else $error("buffer write did not start sending");
    a_rx_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done |=> receive_complete_flag)
        else $error("reception did not set its flag");
    a_wake_rx: assert property (@(posedge pclk) disable iff (!presetn)
        receive_complete_flag && receive_interrupt_enable |=> wake_irq)
        else $error("receive flag did not wake the core");
    a_wake_tx: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(transmit_buffer_free_flag) && transmit_interrupt_enable |=> wake_irq)
        else $error("free flag did not wake the core");
    a_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
        !rxc.continuous_receive_enable |=> !overrun_error_flag)
        else $error("error kept after continuous receive off");
    a_bit3_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && (idx == `IDX_TX_CTL || idx == `IDX_RX_CTL)
        |=> prdata[3] == 1'b0)
        else $error("bit three read as one");
endmodule // usart_sync_slave_baud_gen
`default_nettype wire

// ==== shift_clock_master.sv ====
// behavioural external master that clocks the slave port
`timescale 1ns/1ps
`default_nettype none
module shift_clock_master (
    output logic ck,
    output logic dt_drv,
    input wire logic dt_pin
);
    initial begin
        ck = 1'b0;
        dt_drv = 1'b0;
    end
    //----------------------------------------------------------------
    // frame
    //----------------------------------------------------------------
    // clock stands low between frames; lsb first, data changes while
    // the clock is low and is sampled just as the clock rises
    task automatic frame(input logic [8:0] tx, input int nbits,
                         output logic [8:0] rx);
        rx = '0;
        #37;
        for (int i = 0; i < nbits; i++) begin
            dt_drv = tx[i];
            #40;
            rx[i] = dt_pin;
            ck = 1'b1;
            #80;
            ck = 1'b0;
            #40;
        end
        // a released line must not keep looking like the last bit
        dt_drv = ~dt_drv;
    endtask
endmodule // shift_clock_master
`default_nettype wire

// ==== usart_sync_slave_baud_gen_tb.sv ====
// self-checking bench for the serial port block
`timescale 1ns/1ps
`default_nettype none
`include "usart_params.svh"
module usart_sync_slave_baud_gen_tb;
    logic pclk, presetn, psel, penable, pwrite;
    logic [31:0] paddr, pwdata, prdata, rd_data;
    logic pready, pslverr, ck_out, ck_oe, dt_out, dt_oe;
    logic baud_tick, wake_irq, m_ck, m_dt, ck_in, dt_in, rd_err;
    logic [8:0] got;
    int errors, total_checks;
    // pin level is whoever drives it: device when enabled, else master
    assign ck_in = ck_oe ? ck_out : m_ck;
    assign dt_in = dt_oe ? dt_out : m_dt;
    usart_sync_slave_baud_gen usart_sync_slave_baud_gen_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ck_in(ck_in), .ck_out(ck_out), .ck_oe(ck_oe),
        .dt_in(dt_in), .dt_out(dt_out), .dt_oe(dt_oe),
        .baud_tick(baud_tick), .wake_irq(wake_irq));
    shift_clock_master shift_clock_master_i (.ck(m_ck), .dt_drv(m_dt),
        .dt_pin(dt_in));
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    //----------------------------------------------------------------
    // shared tasks
    //----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] act);
        total_checks++;
        if (act !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) chk("apb answer", 32'h1, 32'h0);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
    endtask
    task automatic rdchk(input string what, input logic [7:0] idx,
                         input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(what, exp, rd_data);
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic tick_gap(output int gap);
        int n;
        n = 0;
        while (baud_tick !== 1'b1 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        gap = 1;
        while (baud_tick !== 1'b1 && gap < 20000) begin
            @(posedge pclk);
            gap++;
        end
    endtask
    //----------------------------------------------------------------
    // scenarios
    //----------------------------------------------------------------
    task automatic t_regs;
        rdchk("tx ctl reset", `IDX_TX_CTL, 32'h02);
        rdchk("rx ctl reset", `IDX_RX_CTL, 32'h00);
        rdchk("divisor reset", `IDX_DIV, 32'h00);
        rdchk("flags reset", `IDX_FLAGS, 32'h10);
        wr(`IDX_TX_CTL, 8'h08);
        rdchk("tx ctl bit3", `IDX_TX_CTL, 32'h02);
        wr(`IDX_RX_CTL, 8'h08);
        rdchk("rx ctl bit3", `IDX_RX_CTL, 32'h00);
        wr(`IDX_DIV, 8'hff);
        rdchk("divisor max", `IDX_DIV, 32'hff);
        apb(1'b0, 8'h01, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, rd_err});
        chk("unmapped data", 32'h0, rd_data);
        $display("test regs done");
    endtask
    task automatic t_baud;
        logic [7:0] ctl [4] = '{8'h00, 8'h04, 8'h90, 8'h94};
        logic [7:0] dv [4] = '{8'h02, 8'h00, 8'h00, 8'h05};
        int mul [4] = '{64, 16, 4, 4};
        int gap;
        int n;
        wr(`IDX_RX_CTL, 8'h80);
        for (int i = 0; i < 4; i++) begin
            wr(`IDX_TX_CTL, ctl[i]);
            wr(`IDX_DIV, dv[i]);
            tick_gap(gap);
            tick_gap(gap);
            chk("bit period", 32'(mul[i] * (int'(dv[i]) + 1)), 32'(gap));
            chk("clock drive", {31'h0, ctl[i][7]}, {31'h0, ck_oe});
        end
        // long old count, then a short one: must not wait the old out
        wr(`IDX_TX_CTL, 8'h00);
        wr(`IDX_DIV, 8'hff);
        wait_cycles(100);
        wr(`IDX_DIV, 8'h00);
        n = 0;
        while (baud_tick !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        chk("tick after divisor write", 32'h1, 32'(n <= 66));
        $display("test baud done");
    endtask
    task automatic t_slave_tx;
        wr(`IDX_RX_CTL, 8'h80);
        wr(`IDX_INT_EN, 8'h10);
        wr(`IDX_TX_CTL, 8'h30);
        wr(`IDX_TX_BUF, 8'ha5);
        wr(`IDX_TX_BUF, 8'h3c);
        rdchk("tx flags busy", `IDX_FLAGS, 32'h00);
        rdchk("tx ctl shifting", `IDX_TX_CTL, 32'h30);
        chk("wake while busy", 32'h0, {31'h0, wake_irq});
        shift_clock_master_i.frame(9'h000, 8, got);
        chk("first word", 32'ha5, {23'h0, got});
        wait_cycles(10);
        rdchk("tx flags free", `IDX_FLAGS, 32'h10);
        chk("wake on free", 32'h1, {31'h0, wake_irq});
        shift_clock_master_i.frame(9'h000, 8, got);
        chk("second word", 32'h3c, {23'h0, got});
        wr(`IDX_TX_CTL, 8'h71);
        wr(`IDX_TX_BUF, 8'h81);
        shift_clock_master_i.frame(9'h000, 9, got);
        chk("nine bit word", 32'h181, {23'h0, got});
        wait_cycles(10);
        rdchk("tx idle", `IDX_TX_CTL, 32'h73);
        $display("test slave transmit done");
    endtask
    task automatic t_slave_rx;
        wr(`IDX_TX_CTL, 8'h10);
        wr(`IDX_INT_EN, 8'h20);
        wr(`IDX_RX_CTL, 8'ha0);
        shift_clock_master_i.frame(9'h05a, 8, got);
        wait_cycles(10);
        rdchk("single receive ignored", `IDX_FLAGS, 32'h10);
        wr(`IDX_RX_CTL, 8'h90);
        shift_clock_master_i.frame(9'h05a, 8, got);
        wait_cycles(10);
        rdchk("rx flag set", `IDX_FLAGS, 32'h30);
        chk("wake on receive", 32'h1, {31'h0, wake_irq});
        rdchk("rx word", `IDX_RX_BUF, 32'h5a);
        rdchk("rx flag cleared", `IDX_FLAGS, 32'h10);
        wr(`IDX_RX_CTL, 8'hd0);
        shift_clock_master_i.frame(9'h1c3, 9, got);
        wait_cycles(10);
        rdchk("rx ninth bit", `IDX_RX_CTL, 32'hd1);
        rdchk("rx nine bit word", `IDX_RX_BUF, 32'hc3);
        wr(`IDX_INT_EN, 8'h00);
        wr(`IDX_RX_CTL, 8'h90);
        shift_clock_master_i.frame(9'h011, 8, got);
        wait_cycles(10);
        chk("no wake when masked", 32'h0, {31'h0, wake_irq});
        shift_clock_master_i.frame(9'h022, 8, got);
        wait_cycles(10);
        apb(1'b0, `IDX_RX_CTL, 8'h00);
        chk("overrun", 32'h2, rd_data & 32'h2);
        wr(`IDX_RX_CTL, 8'h80);
        apb(1'b0, `IDX_RX_CTL, 8'h00);
        chk("overrun cleared", 32'h0, rd_data & 32'h2);
        $display("test slave receive done");
    endtask
    //----------------------------------------------------------------
    // run control
    //----------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        errors++;
        $display("Error watchdog expected end seen hang");
        complete_run();
    end
    initial begin
        errors = 0;
        total_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_baud();
        t_slave_tx();
        t_slave_rx();
        complete_run();
    end
endmodule // usart_sync_slave_baud_gen_tb
`default_nettype wire
